// ===== adcsq_pkg.sv
// Purpose : Shared constants and carrier types for the converter serial sequencer
// Assumes : 125 MHz core clock; 24-bit results; four writable setup registers
// Notes   : Times are kept in ns and turned into cycle counts here
package adcsq_pkg;

   // Clock and timing
   localparam int CLK_PERIOD_NS    = 8;
   localparam int POR_TIME_NS      = 600000;   // Power-on reset interval
   localparam int CONV_PERIOD_NS   = 500000;   // One result every 500 us at 2 kSPS
   localparam int MUX_SETTLE_NS    = 513000;   // Input-select write to result ready
   localparam int SYS_SETTLE_NS    = 575000;   // Rate/gain write to result ready
   localparam int POR_CYC          = (POR_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int CONV_PERIOD_CYC  = CONV_PERIOD_NS / CLK_PERIOD_NS;
   localparam int MUX_SETTLE_CYC   = (MUX_SETTLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int SYS_SETTLE_CYC   = (SYS_SETTLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

   // Data path sizes
   localparam int RESULT_BITS      = 24;
   localparam int FIFO_DEPTH       = 8;

   // Command encodings
   localparam logic [3:0] OPC_WRITE   = 4'h4;   // register_write_cmd upper nibble
   localparam logic [7:0] CMD_CONT_ON = 8'h14;  // Enter continuous_read_mode (lsb ignored)
   localparam logic [7:0] CMD_CONT_OFF= 8'h16;  // Leave continuous_read_mode (lsb ignored)

   // Register addresses
   localparam logic [3:0] REG_INPUT_SELECT = 4'h0;
   localparam logic [3:0] REG_BIAS         = 4'h1;
   localparam logic [3:0] REG_INPUT_CTL    = 4'h2;
   localparam logic [3:0] REG_RATE_GAIN    = 4'h3;

   // Reset values
   localparam logic [7:0] RST_INPUT_SELECT = 8'h01;
   localparam logic [7:0] RST_BIAS         = 8'h00;
   localparam logic [7:0] RST_INPUT_CTL    = 8'h00;
   localparam logic [7:0] RST_RATE_GAIN    = 8'h00;

   // Setup registers as seen by the analog core
   typedef struct packed {
      logic [7:0] input_select_reg;
      logic [7:0] bias_reg;
      logic [7:0] input_ctl_reg;
      logic [7:0] rate_gain_reg;
   } adcsq_cfg_s;

   // Pins arriving from outside the clock domain
   typedef struct packed {
      logic sclk;
      logic cs_n;
      logic din;
      logic start;
   } adcsq_pins_s;

   // Command parser states
   typedef enum logic [1:0] {
      P_CMD,
      P_COUNT,
      P_DATA
   } adcsq_parse_e;

endpackage

// ===== adcsq_fifo.sv
// Purpose : Result FIFO between the conversion core and the serial output
// Assumes : DEPTH is a power of two, at least 2
// Notes   : Read data comes out of a register one cycle after a pop
`timescale 1ns/1ps
`default_nettype none
module adcsq_fifo #(
   parameter int WIDTH = 24,
   parameter int DEPTH = 8
) (
   input  wire logic             clk,
   input  wire logic             rst_n,
   input  wire logic             in_valid,
   output logic                  in_ready,
   input  wire logic [WIDTH-1:0] in_data,
   output logic                  out_valid,
   input  wire logic             out_ready,
   output logic      [WIDTH-1:0] out_data
);
   localparam int AW = $clog2(DEPTH);

   // Refuse depths the pointer logic cannot serve
   if (DEPTH < 2 || (1 << AW) != DEPTH || WIDTH < 1) begin : g_bad_depth
      $error("adcsq_fifo: DEPTH must be a power of two >= 2");
   end

   logic [WIDTH-1:0] mem [DEPTH];
   logic [AW-1:0]    wr_q, wr_d, rd_q, rd_d;
   logic [AW:0]      cnt_q, cnt_d;
   logic             in_ready_q, in_ready_d, out_valid_q, out_valid_d;
   logic [WIDTH-1:0] out_data_q;
   logic             push, pop;

   assign push      = in_valid & in_ready_q;
   assign pop       = out_ready & out_valid_q;
   assign in_ready  = in_ready_q;
   assign out_valid = out_valid_q;
   assign out_data  = out_data_q;

   // Pointer and fill bookkeeping
   always_comb begin
      wr_d        = wr_q + AW'(push);
      rd_d        = rd_q + AW'(pop);
      cnt_d       = cnt_q + (AW+1)'(push) - (AW+1)'(pop);
      in_ready_d  = (cnt_d != (AW+1)'(DEPTH));
      out_valid_d = (cnt_d != '0);
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         wr_q        <= '0;
         rd_q        <= '0;
         cnt_q       <= '0;
         in_ready_q  <= 1'b1;
         out_valid_q <= 1'b0;
      end else begin
         wr_q        <= wr_d;
         rd_q        <= rd_d;
         cnt_q       <= cnt_d;
         in_ready_q  <= in_ready_d;
         out_valid_q <= out_valid_d;
      end
   end

   // Storage and registered read port
   always_ff @(posedge clk) begin
      if (push) begin
         mem[wr_q] <= in_data;
      end
      if (pop) begin
         out_data_q <= mem[rd_q];
      end
   end

endmodule
`default_nettype wire

// ===== adcsq_top.sv
// Purpose : Serial command side and conversion sequencing of a delta-sigma converter
// Assumes : Host is SPI master (mode 1); all pins pass a two-stage synchroniser
// Notes   : Results arrive from the conversion core through an 8-word FIFO
`timescale 1ns/1ps
`default_nettype none
module adcsq_top
   import adcsq_pkg::*;
#(
   parameter int POR_CYCLES  = POR_CYC,
   parameter int PERIOD_CYC  = CONV_PERIOD_CYC,
   parameter int MUX_CYC     = MUX_SETTLE_CYC,
   parameter int SYS_CYC     = SYS_SETTLE_CYC
) (
   input  wire logic                   core_clk,
   input  wire logic                   rst_n,
   input  wire adcsq_pins_s            pins,
   input  wire logic                   res_valid,
   output logic                        res_ready,
   input  wire logic [RESULT_BITS-1:0] res_data,
   output logic                        dout,
   output logic                        dout_oe,
   output logic                        result_ready_n,
   output logic                        asleep,
   output adcsq_cfg_s                  cfg
);
   // Refuse counts the timer cannot serve
   if (MUX_CYC < 2 || SYS_CYC < 2 || PERIOD_CYC < 2 || POR_CYCLES < 1) begin : g_bad_timing
      $error("adcsq_top: timing counts too small");
   end

   // Input synchroniser
   adcsq_pins_s sync1_q, sync2_q;
   logic        sclk_prev_q;
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         sync1_q     <= '{sclk: 1'b0, cs_n: 1'b1, din: 1'b0, start: 1'b1};
         sync2_q     <= '{sclk: 1'b0, cs_n: 1'b1, din: 1'b0, start: 1'b1};
         sclk_prev_q <= 1'b0;
      end else begin
         sync1_q     <= pins;
         sync2_q     <= sync1_q;
         sclk_prev_q <= sync2_q.sclk;
      end
   end

   logic cs_s, rise, fall;
   assign cs_s = sync2_q.cs_n;
   assign rise = !cs_s && sync2_q.sclk && !sclk_prev_q;
   assign fall = !cs_s && !sync2_q.sclk && sclk_prev_q;

   // Result FIFO
   logic                   fifo_valid, fifo_pop;
   logic [RESULT_BITS-1:0] fifo_data;
   adcsq_fifo #(.WIDTH(RESULT_BITS), .DEPTH(FIFO_DEPTH)) u_fifo (
      .clk       (core_clk),
      .rst_n     (rst_n),
      .in_valid  (res_valid),
      .in_ready  (res_ready),
      .in_data   (res_data),
      .out_valid (fifo_valid),
      .out_ready (fifo_pop),
      .out_data  (fifo_data)
   );

   // Serial link state
   logic [2:0]             bit_q, bit_d;
   logic [6:0]             rx_q, rx_d;
   logic [RESULT_BITS-1:0] shift_q, shift_d;
   logic                   dout_q, dout_d, oe_q;
   logic                   byte_done, load_pend_q, load_pend_d, cont_q, cont_d;
   logic [7:0]             rx_byte;

   assign rx_byte   = {rx_q, sync2_q.din};
   assign byte_done = fall && (bit_q == 3'h7);

   // Bit assembly on falling edges, result shift-out on rising edges
   always_comb begin
      bit_d   = bit_q;
      rx_d    = rx_q;
      shift_d = shift_q;
      dout_d  = dout_q;
      if (cs_s) begin
         bit_d = '0;
      end else if (fall) begin
         bit_d = bit_q + 3'h1;
         rx_d  = rx_byte[6:0];
      end
      if (load_pend_q && cont_q) begin
         shift_d = fifo_data;
      end else if (rise) begin
         dout_d  = shift_q[RESULT_BITS-1];
         shift_d = {shift_q[RESULT_BITS-2:0], 1'b0};
      end
   end

   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         bit_q   <= '0;
         rx_q    <= '0;
         shift_q <= '0;
         dout_q  <= 1'b0;
         oe_q    <= 1'b0;
      end else begin
         bit_q   <= bit_d;
         rx_q    <= rx_d;
         shift_q <= shift_d;
         dout_q  <= dout_d;
         oe_q    <= !cs_s;
      end
   end

   // Command parser and setup registers
   adcsq_parse_e st_q, st_d;
   logic [3:0]   addr_q, addr_d, left_q, left_d;
   adcsq_cfg_s   cfg_q, cfg_d;
   logic         wr_mux, wr_sys, por_busy_q, por_busy_d;

   always_comb begin
      st_d   = st_q;
      addr_d = addr_q;
      left_d = left_q;
      cfg_d  = cfg_q;
      cont_d = cont_q;
      wr_mux = 1'b0;
      wr_sys = 1'b0;
      if (cs_s) begin
         st_d = P_CMD;
      end else if (byte_done && !por_busy_q) begin
         case (st_q)
            P_CMD: begin
               if (rx_byte[7:4] == OPC_WRITE) begin
                  addr_d = rx_byte[3:0];
                  st_d   = P_COUNT;
               end else if ({rx_byte[7:1], 1'b0} == CMD_CONT_ON) begin
                  cont_d = 1'b1;
               end else if ({rx_byte[7:1], 1'b0} == CMD_CONT_OFF) begin
                  cont_d = 1'b0;
               end
            end
            P_COUNT: begin
               left_d = rx_byte[3:0];
               st_d   = P_DATA;
            end
            P_DATA: begin
               case (addr_q)
                  REG_INPUT_SELECT: begin
                     cfg_d.input_select_reg = rx_byte;
                     wr_mux = 1'b1;
                  end
                  REG_BIAS:      cfg_d.bias_reg      = rx_byte;
                  REG_INPUT_CTL: cfg_d.input_ctl_reg = rx_byte;
                  REG_RATE_GAIN: begin
                     cfg_d.rate_gain_reg = rx_byte;
                     wr_sys = 1'b1;
                  end
                  default: ;
               endcase
               addr_d = addr_q + 4'h1;
               if (left_q == 4'h0) begin
                  st_d = P_CMD;
               end else begin
                  left_d = left_q - 4'h1;
               end
            end
            default: st_d = P_CMD;
         endcase
      end
   end

   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         st_q   <= P_CMD;
         addr_q <= '0;
         left_q <= '0;
         cont_q <= 1'b1;
         cfg_q  <= '{RST_INPUT_SELECT, RST_BIAS, RST_INPUT_CTL, RST_RATE_GAIN};
      end else begin
         st_q   <= st_d;
         addr_q <= addr_d;
         left_q <= left_d;
         cont_q <= cont_d;
         cfg_q  <= cfg_d;
      end
   end

   // Conversion timer, sleep control and ready pin
   logic [31:0] cnt_q, cnt_d, por_q, por_d;
   logic        sleep_q, sleep_d, rdy_n_q, rdy_n_d, ev;

   assign ev       = !por_busy_q && !sleep_q && !load_pend_q && (cnt_q == '0) && fifo_valid;
   assign fifo_pop = ev;

   always_comb begin
      por_d       = por_q;
      por_busy_d  = por_busy_q;
      cnt_d       = cnt_q;
      sleep_d     = sleep_q;
      rdy_n_d     = rdy_n_q;
      load_pend_d = ev;
      if (por_busy_q) begin
         por_d = por_q + 32'h1;
         if (por_q == 32'(POR_CYCLES - 1)) begin
            por_busy_d = 1'b0;
            cnt_d      = 32'(PERIOD_CYC - 2);
         end
      end else if (wr_mux) begin
         cnt_d = 32'(MUX_CYC - 2);
      end else if (wr_sys) begin
         cnt_d = 32'(SYS_CYC - 2);
      end else if (sleep_q) begin
         if (sync2_q.start) begin
            sleep_d = 1'b0;
            cnt_d   = 32'(PERIOD_CYC - 2);
         end
      end else if (ev) begin
         cnt_d   = 32'(PERIOD_CYC - 1);
         sleep_d = !sync2_q.start;
      end else if (cnt_q != '0 && !load_pend_q) begin
         cnt_d = cnt_q - 32'h1;
      end
      if (load_pend_q) begin
         rdy_n_d = 1'b0;
      end else if (ev || rise) begin
         rdy_n_d = 1'b1; // Event raises ready even when a write restarts the timer
      end
   end

   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         por_q       <= '0;
         por_busy_q  <= 1'b1;
         cnt_q       <= '0;
         sleep_q     <= 1'b0;
         rdy_n_q     <= 1'b1;
         load_pend_q <= 1'b0;
      end else begin
         por_q       <= por_d;
         por_busy_q  <= por_busy_d;
         cnt_q       <= cnt_d;
         sleep_q     <= sleep_d;
         rdy_n_q     <= rdy_n_d;
         load_pend_q <= load_pend_d;
      end
   end

   assign dout           = dout_q;
   assign dout_oe        = oe_q;
   assign result_ready_n = rdy_n_q;
   assign asleep         = sleep_q;
   assign cfg            = cfg_q;

   // Checks
   sequence s_ready_pulse;
      rdy_n_q ##1 !rdy_n_q;
   endsequence

   // Asleep from the cycle after the last event, ready low one cycle later
   sequence s_sleep_settle;
      sleep_q ##1 !rdy_n_q;
   endsequence

   a_por_ready_high: assert property (@(posedge core_clk) disable iff (!rst_n)
      por_busy_q |-> rdy_n_q && !ev) else $error("ready during power-on reset");
   a_event_ready_fall: assert property (@(posedge core_clk) disable iff (!rst_n)
      ev |=> s_ready_pulse) else $error("ready did not fall after event");
   a_cont_loads_result: assert property (@(posedge core_clk) disable iff (!rst_n)
      load_pend_q && cont_q |=> shift_q == $past(fifo_data)) else $error("result not loaded");
   a_mux_restart: assert property (@(posedge core_clk) disable iff (!rst_n)
      wr_mux && !por_busy_q |=> cnt_q == 32'(MUX_CYC - 2) && !ev) else $error("bad mux settle");
   a_sys_restart: assert property (@(posedge core_clk) disable iff (!rst_n)
      wr_sys && !wr_mux && !por_busy_q |=> cnt_q == 32'(SYS_CYC - 2)) else $error("bad rate settle");
   a_sleep_entry: assert property (@(posedge core_clk) disable iff (!rst_n)
      ev && !sync2_q.start && !wr_mux && !wr_sys |=> s_sleep_settle)
      else $error("no sleep after last conversion");
   a_sleep_no_conv: assert property (@(posedge core_clk) disable iff (!rst_n)
      sleep_q && !sync2_q.start && !wr_mux && !wr_sys |=> !load_pend_q && $stable(cnt_q))
      else $error("converted asleep");
   a_shift_out_bit: assert property (@(posedge core_clk) disable iff (!rst_n)
      rise && !load_pend_q |=> dout_q == $past(shift_q[RESULT_BITS-1])) else $error("wrong data bit");
   a_write_stores: assert property (@(posedge core_clk) disable iff (!rst_n)
      wr_mux |=> cfg_q.input_select_reg == $past(rx_byte)) else $error("select not written");

endmodule
`default_nettype wire

// ===== adcsq_host_model.sv
// Purpose : Host controller model, SPI master in mode 1 for the sequencer
// Assumes : sclk stays high for 6 core cycles and low for 7 between bits; sclk rests low between frames
// Notes   : Din is inverted once each time the device is deselected
`timescale 1ns/1ps
`default_nettype none
module adcsq_host_model (
   input  wire logic clk,
   input  wire logic dout,
   output logic      sclk,
   output logic      cs_n,
   output logic      din
);
   // Idle pin levels at time zero
   initial begin
      sclk = 1'b0;
      cs_n = 1'b1;
      din  = 1'b1;
   end

   // One bit: drive on the rise, take dout on the fall
   task automatic bit_x(input logic tx, output logic rx);
      @(negedge clk);
      sclk = 1'b1;
      din  = tx;
      repeat (6) @(negedge clk);
      sclk = 1'b0;
      rx   = dout;
      repeat (6) @(negedge clk);
   endtask

   // Frame edges; din is inverted once deselected
   task automatic frame_open();
      @(negedge clk);
      cs_n = 1'b0;
      repeat (6) @(negedge clk);
   endtask

   task automatic frame_close();
      repeat (6) @(negedge clk);
      cs_n = 1'b1;
      din  = ~din;
   endtask

   // Readout of one 24-bit result, full duplex with 3 command bytes
   task automatic xfer24(input logic [23:0] tx, output logic [23:0] rx);
      frame_open();
      for (int i = 23; i >= 0; i--) begin
         bit_x(tx[i], rx[i]);
      end
      frame_close();
   endtask

   // Six-byte write: opcode and address, count minus one, four data bytes
   task automatic xfer48(input logic [47:0] tx);
      logic unused;
      frame_open();
      for (int i = 47; i >= 0; i--) begin
         bit_x(tx[i], unused);
      end
      frame_close();
   endtask
endmodule
`default_nettype wire

// ===== adc_spi_conversion_sequencing_tb_top.sv
// Purpose : Self-checking bench for the converter serial sequencer
// Assumes : Shortened counts; the bench acts as the conversion core
// Notes   : Host starts each readout after the ready falling edge, except the 16ffff frame sent while asleep
`timescale 1ns/1ps
`default_nettype none
module adc_spi_conversion_sequencing_tb_top;
   import adcsq_pkg::*;
   localparam int POR_C = 800;
   localparam int PER_C = 900;
   localparam int MUX_C = 350;
   localparam int SYS_C = 380;

   logic                   core_clk;
   logic                   rst_n;
   logic                   start;
   logic                   res_valid;
   logic                   res_ready;
   logic [RESULT_BITS-1:0] res_data;
   logic                   dout;
   logic                   dout_oe;
   logic                   result_ready_n;
   logic                   asleep;
   adcsq_cfg_s             cfg;
   adcsq_pins_s            pins;
   logic                   h_sclk;
   logic                   h_cs_n;
   logic                   h_din;
   int                     error_cnt;
   int                     n_tests;
   int                     cyc;

   assign pins = '{sclk: h_sclk, cs_n: h_cs_n, din: h_din, start: start};

   adcsq_top #(.POR_CYCLES(POR_C), .PERIOD_CYC(PER_C), .MUX_CYC(MUX_C), .SYS_CYC(SYS_C)) dut (
      .core_clk       (core_clk),
      .rst_n          (rst_n),
      .pins           (pins),
      .res_valid      (res_valid),
      .res_ready      (res_ready),
      .res_data       (res_data),
      .dout           (dout),
      .dout_oe        (dout_oe),
      .result_ready_n (result_ready_n),
      .asleep         (asleep),
      .cfg            (cfg)
   );

   adcsq_host_model host (
      .clk  (core_clk),
      .dout (dout),
      .sclk (h_sclk),
      .cs_n (h_cs_n),
      .din  (h_din)
   );

   // Core clock, 8 ns period
   initial begin
      core_clk = 1'b0;
      forever #4 core_clk = ~core_clk;
   end

   // Hang guard
   always @(posedge core_clk) begin
      cyc++;
      if (cyc == 20000) begin
         error_cnt++;
         tally_and_finish();
      end
   end

   function automatic logic [23:0] word(input int i);
      return {8'hc3, 8'(i), 8'h3c ^ 8'(i)};
   endfunction

   task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
      n_tests++;
      if (got !== exp) begin
         error_cnt++;
         $display("wrong value %s expected %h seen %h", nm, exp, got);
      end
   endtask

   task automatic chk_win(input string nm, input int lo, input int hi, input int got);
      n_tests++;
      if (got < lo || got > hi) begin
         error_cnt++;
         $display("wrong value %s expected %0d..%0d seen %0d", nm, lo, hi, got);
      end
   endtask

   // Bounded wait for the ready falling edge
   task automatic wait_rdy(output int n);
      n = 0;
      while (result_ready_n !== 1'b0 && n < 3000) begin
         @(negedge core_clk);
         n++;
      end
   endtask

   // Reset values, FIFO fill to refusal, write during power-on busy
   task automatic t_reset_fill();
      chk("cfg_reset", 32'h01000000, cfg);
      chk("rdy_reset", 32'h1, {31'h0, result_ready_n});
      for (int i = 0; i < 8; i++) begin
         chk("res_ready_fill", 32'h1, {31'h0, res_ready});
         res_valid = 1'b1;
         res_data  = word(i);
         @(negedge core_clk);
      end
      res_valid = 1'b0;
      chk("res_ready_full", 32'h0, {31'h0, res_ready});
      host.xfer48(48'h4003aabbccdd);
      chk("cfg_busy_ignored", 32'h01000000, cfg);
      repeat (250) @(negedge core_clk);
   endtask

   // Block setup write, then ready after the rate/gain settle time
   task automatic t_setup();
      int n;
      host.xfer48(48'h400312345678);
      chk("cfg_setup", 32'h12345678, cfg);
      wait_rdy(n);
      chk_win("setup_to_ready", SYS_C - 16, SYS_C, n);
      chk("oe_idle", 32'h0, {31'h0, dout_oe});
   endtask

   // Readout with input-select write in the same 24 clocks
   task automatic t_readout_switch();
      int          n;
      logic [23:0] rx;
      host.xfer24(24'h400023, rx);
      chk("readout_w0", {8'h0, word(0)}, {8'h0, rx});
      chk("cfg_mux", 32'h23, {24'h0, cfg.input_select_reg});
      chk("rdy_after_read", 32'h1, {31'h0, result_ready_n});
      chk("res_ready_drain", 32'h1, {31'h0, res_ready});
      wait_rdy(n);
      chk_win("mux_to_ready", MUX_C - 16, MUX_C, n);
   endtask

   // Start low: pending conversion completes, then sleep with result kept
   task automatic t_sleep();
      int          n;
      logic [23:0] rx;
      start = 1'b0;
      host.xfer24(24'hffffff, rx);
      chk("readout_w1", {8'h0, word(1)}, {8'h0, rx});
      chk("awake_pending", 32'h0, {31'h0, asleep});
      wait_rdy(n);
      chk_win("last_event", 1, PER_C, n);
      repeat (3) @(negedge core_clk);
      chk("asleep", 32'h1, {31'h0, asleep});
      host.xfer24(24'hffffff, rx);
      chk("sleep_readout", {8'h0, word(2)}, {8'h0, rx});
      wait_rdy(n);
      chk("no_event_asleep", 32'h1, {31'h0, result_ready_n});
      chk("still_asleep", 32'h1, {31'h0, asleep});
   endtask

   // Output enable in a frame, wake by start, continuous mode off and on again
   task automatic t_cont_cmds();
      int          n;
      logic [23:0] rx;
      host.frame_open();
      chk("oe_active", 32'h1, {31'h0, dout_oe});
      host.frame_close();
      host.xfer24(24'h16ffff, rx);
      start = 1'b1;
      wait_rdy(n);
      chk("awake", 32'h0, {31'h0, asleep});
      chk_win("wake_to_ready", PER_C - 16, PER_C + 4, n);
      host.xfer24(24'h14ffff, rx);
      chk("cont_off_no_load", 32'h0, {31'h0, rx == word(3)});
      wait_rdy(n);
      host.xfer24(24'hffffff, rx);
      chk("cont_on_load", {8'h0, word(4)}, {8'h0, rx});
   endtask

   task automatic tally_and_finish();
      $display("Comparisons %0d mismatches %0d", n_tests, error_cnt);
      if (error_cnt == 0 && n_tests > 0) begin
         $display("Result: passed");
      end else begin
         $display("Result: failed");
      end
      $finish;
   endtask

   // Main sequence: reset for 2 cycles, then the scenarios
   initial begin
      error_cnt = 0;
      n_tests   = 0;
      cyc       = 0;
      rst_n     = 1'b0;
      start     = 1'b1;
      res_valid = 1'b0;
      res_data  = '0;
      repeat (2) @(posedge core_clk);
      @(negedge core_clk);
      rst_n = 1'b1;
      t_reset_fill();
      t_setup();
      t_readout_switch();
      t_sleep();
      t_cont_cmds();
      tally_and_finish();
   end
endmodule
`default_nettype wire
